// *** pucms_pkg.sv ***
// pucms_pkg: constants for the power-up / configuration mode sequencer
// assumes a 250 MHz system clock
package pucms_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned POR_LONG_MS = 100;
	localparam int unsigned POR_SHORT_MS = 2;
	localparam int unsigned POR_LONG_CYC = POR_LONG_MS * 1000 * CLK_MHZ;
	localparam int unsigned POR_SHORT_CYC = POR_SHORT_MS * 1000 * CLK_MHZ;
	localparam int unsigned LOAD_LIMIT_MS = 100;
	localparam int unsigned LOAD_LIMIT_CYC = LOAD_LIMIT_MS * 1000 * CLK_MHZ;
	localparam int unsigned CNT_W = 32;
	localparam int unsigned WORD_W = 8;
	localparam int unsigned INSTR_W = 10;
	localparam logic [9:0] SCAN_RECONFIG_TRIGGER_INSTR = 10'h001;
	localparam int unsigned MAX_CHAIN_POS = 17;
	localparam int unsigned CHAIN_POS_W = 8;
	localparam int unsigned INIT_CYC = 8;
	localparam int unsigned IO_W = 16;
	typedef enum logic [2:0] {
		PUCMS_POR, PUCMS_WAIT, PUCMS_LOAD, PUCMS_INIT, PUCMS_USER, PUCMS_FAIL
	} pucms_state_t;
endpackage

// *** pucms_sync.sv ***
// pucms_sync: two-flop synchroniser for one pin level
// assumes clk and clock enable of the sequencer
`timescale 1ns/1ps
module pucms_sync (
	// clock and reset
	input wire logic clk,
	input wire logic ce,
	input wire logic reset_n,
	// data
	input wire logic rst_val,
	input wire logic d,
	output logic q
);
	logic meta;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meta <= rst_val;
			q <= rst_val;
		end else if (ce) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// *** pucms_top.sv ***
// pucms_top: power-up delay, configuration mode and user mode sequencing
// assumes pins are synchronised here; reset_n is the power-up event
`timescale 1ns/1ps
module pucms_top
	import pucms_pkg::*;
#(
	parameter int unsigned POR_LONG = POR_LONG_CYC,
	parameter int unsigned POR_SHORT = POR_SHORT_CYC,
	parameter int unsigned LOAD_LIMIT = LOAD_LIMIT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic ce,
	input wire logic reset_n,
	// straps and control pins
	input wire logic power_on_delay_select,
	input wire logic io_weak_pull_control_n,
	input wire logic reconfig_request_n,
	// boundary-scan side
	input wire logic scan_instr_valid,
	input wire logic [INSTR_W-1:0] scan_instr,
	input wire logic scan_path,
	input wire logic [CHAIN_POS_W-1:0] chain_position,
	// configuration data
	input wire logic cfg_valid,
	input wire logic [WORD_W-1:0] cfg_data,
	input wire logic cfg_last,
	// user I/O
	input wire logic [IO_W-1:0] user_out,
	input wire logic [IO_W-1:0] user_oe,
	output logic [IO_W-1:0] io_out,
	output logic [IO_W-1:0] io_oe,
	output logic io_pullup_en,
	// status
	output logic cfg_ready,
	output logic cfg_error,
	output logic user_mode,
	output logic init_reset,
	output logic [WORD_W-1:0] cfg_word,
	output logic cfg_word_strobe
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic sel_s;
	logic pull_n_s;
	logic req_n_s;
	pucms_sync u_sel (.clk(clk), .ce(ce), .reset_n(reset_n),
		.rst_val(1'b0), .d(power_on_delay_select), .q(sel_s));
	pucms_sync u_pull (.clk(clk), .ce(ce), .reset_n(reset_n),
		.rst_val(1'b1), .d(io_weak_pull_control_n), .q(pull_n_s));
	pucms_sync u_req (.clk(clk), .ce(ce), .reset_n(reset_n),
		.rst_val(1'b1), .d(reconfig_request_n), .q(req_n_s));

	// ------------------------------------------------------------
	// reconfiguration triggers
	// ------------------------------------------------------------
	logic req_n_d;
	logic pin_fall;
	logic scan_trig;
	logic reconfig;
	always_ff @(posedge clk) begin
		if (!reset_n)
			req_n_d <= 1'b1;
		else if (ce)
			req_n_d <= req_n_s;
	end
	assign pin_fall = req_n_d && !req_n_s;
	assign scan_trig = scan_instr_valid &&
		(scan_instr == SCAN_RECONFIG_TRIGGER_INSTR);
	assign reconfig = pin_fall || scan_trig;

	// ------------------------------------------------------------
	// delay select latch
	// ------------------------------------------------------------
	logic sel_taken;
	logic sel_lat;
	logic [1:0] sel_wait;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sel_taken <= 1'b0;
			sel_lat <= 1'b0;
			sel_wait <= 2'h0;
		end else if (ce && !sel_taken) begin
			// sync still holds its reset value for two edges
			if (sel_wait == 2'h2) begin
				sel_taken <= 1'b1;
				sel_lat <= sel_s;
			end else begin
				sel_wait <= sel_wait + 2'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	pucms_state_t state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] por_len;
	logic scan_bad;
	assign por_len = sel_lat ? CNT_W'(POR_SHORT) : CNT_W'(POR_LONG);
	assign scan_bad = scan_path &&
		(chain_position > CHAIN_POS_W'(MAX_CHAIN_POS));

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= PUCMS_POR;
			cnt <= '0;
		end else if (ce) begin
			case (state)
			PUCMS_POR: begin
				if (sel_taken) begin
					state <= PUCMS_WAIT;
					cnt <= '0;
				end
			end
			PUCMS_WAIT: begin
				cnt <= cnt + 1'b1;
				if (cnt + 1'b1 >= por_len) begin
					state <= PUCMS_LOAD;
					cnt <= '0;
				end
			end
			PUCMS_LOAD: begin
				cnt <= cnt + 1'b1;
				if (scan_bad)
					state <= PUCMS_FAIL;
				else if (cnt + 1'b1 >= CNT_W'(LOAD_LIMIT))
					state <= PUCMS_FAIL;
				else if (cfg_valid && cfg_last) begin
					state <= PUCMS_INIT;
					cnt <= '0;
				end
			end
			PUCMS_INIT: begin
				cnt <= cnt + 1'b1;
				if (cnt + 1'b1 >= CNT_W'(INIT_CYC)) begin
					state <= PUCMS_USER;
					cnt <= '0;
				end
			end
			PUCMS_USER: begin
				if (reconfig) begin
					state <= PUCMS_LOAD;
					cnt <= '0;
				end
			end
			PUCMS_FAIL: begin
				if (reconfig) begin
					state <= PUCMS_LOAD;
					cnt <= '0;
				end
			end
			default: begin
				state <= PUCMS_POR;
				cnt <= '0;
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			io_out <= '0;
			io_oe <= '0;
			io_pullup_en <= 1'b0;
			user_mode <= 1'b0;
			cfg_ready <= 1'b0;
			cfg_error <= 1'b0;
			init_reset <= 1'b1;
		end else if (ce) begin
			user_mode <= (state == PUCMS_USER);
			io_out <= (state == PUCMS_USER) ? user_out : '0;
			io_oe <= (state == PUCMS_USER) ? user_oe : '0;
			io_pullup_en <= (state != PUCMS_USER) && !pull_n_s;
			cfg_ready <= (state == PUCMS_LOAD);
			cfg_error <= (state == PUCMS_FAIL);
			init_reset <= (state != PUCMS_USER);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg_word <= '0;
			cfg_word_strobe <= 1'b0;
		end else if (ce) begin
			cfg_word_strobe <= (state == PUCMS_LOAD) && cfg_valid && !scan_bad;
			if ((state == PUCMS_LOAD) && cfg_valid)
				cfg_word <= cfg_data;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_io_hiz;
		@(posedge clk) disable iff (!reset_n)
		ce && (state != PUCMS_USER) |=> (io_oe == '0);
	endproperty
	a_io_hiz: assert property (p_io_hiz)
		else $error("io driven outside user mode");

	property p_pull;
		@(posedge clk) disable iff (!reset_n)
		ce && (state != PUCMS_USER) |=> (io_pullup_en == !$past(pull_n_s));
	endproperty
	a_pull: assert property (p_pull)
		else $error("pull-up state wrong");

	property p_wait_len;
		@(posedge clk) disable iff (!reset_n)
		(state == PUCMS_WAIT) && (cnt != '0) |-> (cnt < por_len);
	endproperty
	a_wait_len: assert property (p_wait_len)
		else $error("por delay overrun");

	property p_sel_hold;
		@(posedge clk) disable iff (!reset_n)
		sel_taken && $past(sel_taken) |-> $stable(sel_lat);
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("select relatched");

	sequence s_load_done;
		ce && (state == PUCMS_LOAD) && cfg_valid && cfg_last && !scan_bad &&
		(cnt + 1'b1 < CNT_W'(LOAD_LIMIT));
	endsequence
	property p_init;
		@(posedge clk) disable iff (!reset_n)
		s_load_done |=> (state == PUCMS_INIT);
	endproperty
	a_init: assert property (p_init)
		else $error("no init after load");

	property p_reconf;
		@(posedge clk) disable iff (!reset_n)
		ce && (state == PUCMS_USER) && reconfig |=> (state == PUCMS_LOAD);
	endproperty
	a_reconf: assert property (p_reconf)
		else $error("reconfig ignored");

	property p_scan_instr;
		@(posedge clk) disable iff (!reset_n)
		ce && (state == PUCMS_USER) && scan_instr_valid &&
		(scan_instr == SCAN_RECONFIG_TRIGGER_INSTR) |=>
		(state == PUCMS_LOAD) ##1 !user_mode;
	endproperty
	a_scan_instr: assert property (p_scan_instr)
		else $error("scan trigger ignored");

	property p_chain;
		@(posedge clk) disable iff (!reset_n)
		ce && (state == PUCMS_LOAD) && scan_bad |=> (state == PUCMS_FAIL);
	endproperty
	a_chain: assert property (p_chain)
		else $error("deep chain accepted");

	property p_limit;
		@(posedge clk) disable iff (!reset_n)
		(state == PUCMS_LOAD) |-> (cnt < CNT_W'(LOAD_LIMIT));
	endproperty
	a_limit: assert property (p_limit)
		else $error("load over limit");
endmodule

// *** pucms_src.sv ***
// pucms_src: model of the configuration word source
// assumes the sequencer takes words while cfg_ready is high
`timescale 1ns/1ps
module pucms_src
	import pucms_pkg::*;
(
	// clock
	input wire logic clk,
	// control
	input wire logic cfg_ready,
	input wire logic stall,
	// words
	output logic cfg_valid,
	output logic [WORD_W-1:0] cfg_data,
	output logic cfg_last
);
	logic [3:0] cnt = 4'h0;
	initial begin
		cfg_valid = 1'b0;
		cfg_data = 8'h00;
		cfg_last = 1'b0;
	end
	// ----
	// one 8-bit word a cycle, four words an image
	// ----
	always @(negedge clk) begin
		if (!cfg_ready || stall || cnt == 4'h4) begin
			cfg_valid <= 1'b0;
			cfg_data <= ~cfg_data;
			if (!cfg_ready) begin
				cnt <= 4'h0;
			end
		end else begin
			cfg_valid <= 1'b1;
			cfg_data <= 8'ha0 + {4'h0, cnt};
			cfg_last <= cnt == 4'h3;
			cnt <= cnt + 4'h1;
		end
	end
endmodule

// *** pucms_top_tb.sv ***
// pucms_top_tb: self-checking bench of the mode sequencer
// assumes short delay parameters and the word source model
`timescale 1ns/1ps
module pucms_top_tb;
	import pucms_pkg::*;
	localparam int PL = 200;
	localparam int PS = 20;
	localparam int LL = 1000;
	typedef struct packed {
		logic sel;
		logic pn;
		logic sp;
		logic [7:0] pos;
		logic err;
	} pucms_row_t;
	pucms_row_t rows [4] = '{'{1, 1, 1, 8'h12, 1}, '{0, 0, 1, 8'h11, 0},
		'{0, 1, 0, 8'h40, 0}, '{1, 0, 1, 8'h03, 0}};
	logic clk = 0, reset_n = 0, sel = 0, pull_n = 1, rq_n = 1, stall = 0;
	logic iv = 0, sp = 1, ce = 1, cv, cl, pu, rdy, er, um, ir, ws;
	logic [9:0] instr = 10'h000;
	logic [7:0] pos = 8'h01, cd, cw;
	logic [15:0] io_out, io_oe;
	logic [2:0] flags;
	int n, num_errors = 0, n_compared = 0;
	int n_words = 0;
	assign flags = {er, um, rdy};
	always @(negedge clk) begin
		if (ws === 1'b1) begin
			n_words++;
		end
	end
	initial begin
		forever #2 clk = ~clk;
	end
	pucms_top #(.POR_LONG(PL), .POR_SHORT(PS), .LOAD_LIMIT(LL)) DUT (
		.clk(clk), .ce(ce), .reset_n(reset_n),
		.power_on_delay_select(sel), .io_weak_pull_control_n(pull_n),
		.reconfig_request_n(rq_n), .scan_instr_valid(iv),
		.scan_instr(instr), .scan_path(sp), .chain_position(pos),
		.cfg_valid(cv), .cfg_data(cd), .cfg_last(cl),
		.user_out(16'h5a3c), .user_oe(16'hf00f), .io_out(io_out),
		.io_oe(io_oe), .io_pullup_en(pu), .cfg_ready(rdy),
		.cfg_error(er), .user_mode(um), .init_reset(ir),
		.cfg_word(cw), .cfg_word_strobe(ws));
	pucms_src SRC (.clk(clk), .cfg_ready(rdy), .stall(stall),
		.cfg_valid(cv), .cfg_data(cd), .cfg_last(cl));
	// ----
	// helpers
	// ----
	task automatic give_verdict();
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int s, input int lim);
		n = 0;
		while (flags[s] !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				num_errors++;
				give_verdict();
			end
		end
	endtask
	task automatic scan(input logic [9:0] code);
		@(negedge clk);
		instr = code;
		iv = 1;
		@(negedge clk);
		iv = 0;
	endtask
	task automatic user_check();
		wt(1, 40);
		chk(io_oe, 16'hf00f);
		chk(io_out, 16'h5a3c);
		chk({ir, pu}, 2'b00);
		chk(cw, 8'ha3);
		chk(n_words, 4);
		n_words = 0;
	endtask
	// ----
	// sequence
	// ----
	initial begin
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			{sel, pull_n, sp, pos} = {rows[i].sel, rows[i].pn, rows[i].sp,
				rows[i].pos};
			reset_n = 0;
			repeat (12) @(negedge clk);
			chk({io_oe, ir, um}, 18'h2);
			reset_n = 1;
			repeat (6) @(negedge clk);
			sel = ~sel;
			wt(0, 400);
			chk(io_oe, 16'h0);
			chk(pu, !rows[i].pn);
			n = n + 6 - (rows[i].sel ? PS : PL);
			chk(n >= -4 && n <= 8, 1);
			if (rows[i].err) begin
				wt(2, 20);
			end else begin
				user_check();
			end
		end
		rq_n = 0;
		wt(0, 10);
		chk({um, io_oe, pu}, 18'h1);
		rq_n = 1;
		user_check();
		scan(10'h005);
		repeat (6) @(negedge clk);
		chk(rdy, 0);
		ce = 0;
		scan(10'h001);
		repeat (4) @(negedge clk);
		chk({rdy, um}, 2'b01);
		ce = 1;
		scan(10'h001);
		wt(0, 6);
		user_check();
		stall = 1;
		scan(10'h001);
		wt(0, 6);
		wt(2, LL + 20);
		chk(n >= LL - 5 && n <= LL + 5, 1);
		stall = 0;
		rq_n = 0;
		wt(0, 10);
		rq_n = 1;
		user_check();
		give_verdict();
	end
endmodule
